// ---- design/bridge_pwm_output_control.sv ----
`timescale 1ns/1ps
// What this block does
// - direction bit applied on next PWM cycle
// - four counts early: B,D off, swap A/C
// - no dead-band in full-bridge
// - shutdown source chosen by three-bit select
// - status bit shows shutdown state
// - status set on event, held until cleared
// - shutdown forces outputs without period wait
// - per-pair shutdown level: high, low, Z
// - shutdown is level sensitive
// - status writes ignored while condition present
// - restart resumes at next period start
// - auto restart only when enable bit set
// - auto restart clears status when condition ends
// - half-bridge delay on rising activity only
// - seven-bit dead-band count in cycles
// - steering when mode 11 and config 00
// - same waveform on every steered output
// - low mode bits pick output polarity
// - steering shutdown affects enabled outputs only
// - forward: A on, D modulated; reverse mirrored
// - dead-band over duty keeps output inactive
// - steering sync: immediate or next period
module bridge_pwm_output_control #(
	parameter int TMR_W = 8
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic pwm_in,
	input wire logic period_start,
	input wire logic [TMR_W-1:0] tmr_count,
	input wire logic [TMR_W-1:0] tmr_period,
	input wire logic int_pin_n,
	input wire logic comparator_output,
	output logic pwm_out_a,
	output logic pwm_out_a_oe,
	output logic pwm_out_b,
	output logic pwm_out_b_oe,
	output logic pwm_out_c,
	output logic pwm_out_c_oe,
	output logic pwm_out_d,
	output logic pwm_out_d_oe
);
	// ==========================================================
	// register bus
	bridge_pwm_pkg::bus_req_t req_r;
	logic [7:0] chan_r, sdc_r, dbr_r, rdata_r;
	logic [4:0] steer_w_r;
	logic [3:0] steer_r;
	logic ase_r, hold_r, dir_r, chg_r, pwm_d_r;
	logic [6:0] db_cnt_r;
	logic int_s1_r, int_s2_r, cmp_s1_r, cmp_s2_r;
	logic [7:0] rd_mux;
	wire src_hit;
	bridge_pwm_pkg::pins_t pins_r, pins_nxt;

	// zero wait state slave, always OKAY
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = {24'h000000, rdata_r};

	wire take = hsel & htrans[1] & hready;
	wire [7:0] a_ofs = haddr[7:0];
	wire wr_chan = req_r.wr & (req_r.addr == bridge_pwm_pkg::CHANNEL_CONTROL_OFS);
	wire wr_sdc = req_r.wr & (req_r.addr == bridge_pwm_pkg::SHUTDOWN_CONTROL_OFS);
	wire wr_dbr = req_r.wr & (req_r.addr == bridge_pwm_pkg::DEADBAND_RESTART_OFS);
	wire wr_steer = req_r.wr & (req_r.addr == bridge_pwm_pkg::STEERING_CONTROL_OFS);

	// ==========================================================
	// field decode
	wire [1:0] cfg = chan_r[bridge_pwm_pkg::CFG_POS +: 2];
	wire [1:0] mode_upper_bits = chan_r[bridge_pwm_pkg::MODE_UP_POS +: 2];
	wire [1:0] polarity_select_bits = chan_r[bridge_pwm_pkg::POL_POS +: 2];
	wire bridge_direction_bit = cfg[1];
	wire [2:0] shutdown_source_select = sdc_r[bridge_pwm_pkg::SRC_POS +: 3];
	wire [1:0] pair_ac_shutdown_level = sdc_r[bridge_pwm_pkg::LVL_AC_POS +: 2];
	wire [1:0] pair_bd_shutdown_level = sdc_r[bridge_pwm_pkg::LVL_BD_POS +: 2];
	wire auto_restart_enable = dbr_r[bridge_pwm_pkg::RSEN_POS];
	wire [6:0] deadband_count = dbr_r[bridge_pwm_pkg::DBC_POS +: 7];
	wire steering_sync_select = steer_w_r[bridge_pwm_pkg::SYNC_POS];
	wire [3:0] steering_pin_enables = steer_w_r[bridge_pwm_pkg::STEER_POS +: 4];
	wire pwm_on = (mode_upper_bits == bridge_pwm_pkg::MODE_PWM);
	wire half = pwm_on & (cfg == bridge_pwm_pkg::CFG_HALF);
	wire full = pwm_on & cfg[0];
	wire steering = pwm_on & (cfg == bridge_pwm_pkg::CFG_SINGLE);
	// polarity: a set bit makes that pair active low
	wire pol_ac = polarity_select_bits[1];
	wire pol_bd = polarity_select_bits[0];

	// address phase capture; read data registered for the data phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			req_r <= '0;
			rdata_r <= 8'h00;
		end else begin
			req_r <= '{wr: take & hwrite, rd: take & ~hwrite, addr: a_ofs};
			rdata_r <= rd_mux;
		end
	end

	// unmapped offsets read zero
	// status bit readback
	wire [7:0] stat_word = {pins_r.lvl, hold_r, src_hit, chg_r, dir_r};
	always_comb begin
		case (a_ofs)
			bridge_pwm_pkg::CHANNEL_CONTROL_OFS: rd_mux = chan_r;
			bridge_pwm_pkg::SHUTDOWN_CONTROL_OFS: rd_mux = {ase_r, sdc_r[6:0]};
			bridge_pwm_pkg::DEADBAND_RESTART_OFS: rd_mux = dbr_r;
			bridge_pwm_pkg::STEERING_CONTROL_OFS: rd_mux = {3'h0, steer_w_r};
			bridge_pwm_pkg::STATUS_OFS: rd_mux = stat_word;
			default: rd_mux = 8'h00;
		endcase
	end

	// control registers written in the data phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			chan_r <= bridge_pwm_pkg::CHANNEL_CONTROL_RST;
			sdc_r <= bridge_pwm_pkg::SHUTDOWN_CONTROL_RST;
			dbr_r <= bridge_pwm_pkg::DEADBAND_RESTART_RST;
			steer_w_r <= bridge_pwm_pkg::STEERING_CONTROL_RST;
		end else begin
			if (wr_chan)
				chan_r <= hwdata[7:0];
			if (wr_sdc)
				sdc_r <= hwdata[7:0];
			if (wr_dbr)
				dbr_r <= hwdata[7:0];
			if (wr_steer)
				steer_w_r <= hwdata[4:0];
		end
	end

	// ==========================================================
	// shutdown sources: pins cross two flops before use
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			int_s1_r <= 1'b1;
			int_s2_r <= 1'b1;
			cmp_s1_r <= 1'b0;
			cmp_s2_r <= 1'b0;
		end else begin
			int_s1_r <= int_pin_n;
			int_s2_r <= int_s1_r;
			cmp_s1_r <= comparator_output;
			cmp_s2_r <= cmp_s1_r;
		end
	end

	// source select: bit0 comparator, bit1 pin low
	assign src_hit = (shutdown_source_select[0] & cmp_s2_r)
		| (shutdown_source_select[1] & ~int_s2_r);
	wire fw_set = wr_sdc & hwdata[bridge_pwm_pkg::ASE_POS];
	wire fw_clr = wr_sdc & ~hwdata[bridge_pwm_pkg::ASE_POS];

	// status bit: a live source wins over any clear
	logic ase_nxt;
	always_comb begin
		ase_nxt = ase_r;
		if (auto_restart_enable & ~src_hit & ~fw_set)
			ase_nxt = 1'b0;
		if (fw_clr & ~src_hit)
			ase_nxt = 1'b0;
		if (src_hit | fw_set)
			ase_nxt = 1'b1;
	end

	// with auto restart enabled, hardware clears when the source goes away
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			ase_r <= 1'b0;
		else
			ase_r <= ase_nxt;
	end

	// outputs stay parked until a fresh period starts
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			hold_r <= 1'b0;
		else if (ase_r | src_hit)
			hold_r <= 1'b1;
		else if (period_start)
			hold_r <= 1'b0;
	end
	// forced while the source, the status bit or the period hold is set
	wire forced = ase_r | src_hit | hold_r;

	// ==========================================================
	// full-bridge direction change
	wire [TMR_W-1:0] lead = TMR_W'(bridge_pwm_pkg::DIR_LEAD_COUNTS);
	wire near_end = (tmr_count == tmr_period - lead);
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dir_r <= 1'b0;
			chg_r <= 1'b0;
		end else begin
			// new direction waits for the lead point, four counts before the period end
			// swap early and blank the modulated pair
			if (full & near_end & (bridge_direction_bit != dir_r)) begin
				dir_r <= bridge_direction_bit;
				chg_r <= 1'b1;
			end else if (period_start) begin
				chg_r <= 1'b0;
			end
		end
	end

	// ==========================================================
	// half-bridge dead-band: cycles since the last waveform edge
	wire pwm_edge = pwm_in ^ pwm_d_r;
	wire [6:0] elapsed = pwm_edge ? 7'h00 : db_cnt_r;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pwm_d_r <= 1'b0;
			db_cnt_r <= 7'h00;
		end else begin
			pwm_d_r <= pwm_in;
			if (pwm_edge)
				db_cnt_r <= 7'h01;
			else if (db_cnt_r != 7'h7F)
				db_cnt_r <= db_cnt_r + 7'h01;
		end
	end
	// count in clock cycles, seven bits
	// a count past the duty never lets the output go active
	// zero count passes the edge through
	wire db_done = (elapsed >= deadband_count);
	// only the turn-on edge is delayed
	wire half_a = pwm_in & db_done;
	wire half_b = ~pwm_in & db_done;

	// ==========================================================
	// steering enables, immediate or period aligned
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			steer_r <= bridge_pwm_pkg::STEERING_CONTROL_RST[3:0];
		// sync bit picks when the enables land
		else if (~steering_sync_select | period_start)
			steer_r <= steering_pin_enables;
	end

	// ==========================================================
	// active-level pattern per mode, before polarity
	logic [3:0] act, en;
	always_comb begin
		act = 4'h0;
		en = 4'h0;
		if (steering) begin
			// one waveform on each steered output
			act = {4{pwm_in}};
			en = steer_r;
		end else if (half) begin
			act = {2'b00, half_b, half_a};
			en = 4'h3;
		end else if (full) begin
			// forward A on/D modulated, reverse C on/B modulated
			act[0] = ~dir_r;
			act[2] = dir_r;
			act[3] = ~dir_r & pwm_in & ~chg_r;
			act[1] = dir_r & pwm_in & ~chg_r;
			en = 4'hF;
		end else if (pwm_on) begin
			act = {3'h0, pwm_in};
			en = 4'h1;
		end
	end

	// shutdown level for one pair: drive 0, drive 1, else float
	function automatic logic [1:0] park(input logic [1:0] sel);
		park = 2'b00;
		case (sel)
			bridge_pwm_pkg::LVL_DRIVE0: park = 2'b01;
			bridge_pwm_pkg::LVL_DRIVE1: park = 2'b11;
			default: park = 2'b00;
		endcase
	endfunction

	wire [1:0] park_ac = park(pair_ac_shutdown_level);
	wire [1:0] park_bd = park(pair_bd_shutdown_level);
	wire [3:0] pol = {pol_bd, pol_ac, pol_bd, pol_ac};
	wire [3:0] park_lvl = {park_bd[1], park_ac[1], park_bd[1], park_ac[1]};
	wire [3:0] park_oe = {park_bd[0], park_ac[0], park_bd[0], park_ac[0]};

	// forcing overrides the waveform at once, no period wait
	always_comb begin
		pins_nxt.lvl = act ^ pol;
		pins_nxt.oe = en;
		if (forced) begin
			pins_nxt.lvl = park_lvl & en;
			pins_nxt.oe = park_oe & en;
		end
	end

	// registered pin drive; released pins read low
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			pins_r <= '0;
		else
			pins_r <= '{lvl: pins_nxt.lvl & pins_nxt.oe, oe: pins_nxt.oe};
	end

	assign pwm_out_a = pins_r.lvl[0];
	assign pwm_out_b = pins_r.lvl[1];
	assign pwm_out_c = pins_r.lvl[2];
	assign pwm_out_d = pins_r.lvl[3];
	assign pwm_out_a_oe = pins_r.oe[0];
	assign pwm_out_b_oe = pins_r.oe[1];
	assign pwm_out_c_oe = pins_r.oe[2];
	assign pwm_out_d_oe = pins_r.oe[3];

	// ==========================================================
	// checks
	sequence s_dir_pending;
		full && (bridge_direction_bit != dir_r) && !near_end;
	endsequence

	sequence s_swap;
		full && near_end && (bridge_direction_bit != dir_r);
	endsequence

	a_dir_waits: assert property (@(posedge hclk) disable iff (!hresetn)
		s_dir_pending |=> $stable(dir_r))
		else $error("direction changed away from the lead point");

	a_swap_blanks: assert property (@(posedge hclk) disable iff (!hresetn)
		s_swap ##1 (!forced && !period_start) |=> pins_r.lvl[1] == pol_bd
		&& pins_r.lvl[3] == pol_bd && pins_r.lvl[0] == (pol_ac ^ ~dir_r))
		else $error("modulated pair not blanked on swap");

	a_status_sets: assert property (@(posedge hclk) disable iff (!hresetn)
		src_hit |=> ase_r [*1] ##0 hold_r)
		else $error("status not set by shutdown source");

	a_clear_blocked: assert property (@(posedge hclk) disable iff (!hresetn)
		(fw_clr && src_hit) |=> ase_r)
		else $error("status cleared under live condition");

	a_auto_restart: assert property (@(posedge hclk) disable iff (!hresetn)
		(auto_restart_enable && ase_r && !src_hit && !fw_set) |=> !ase_r)
		else $error("auto restart did not clear status");

	a_no_auto: assert property (@(posedge hclk) disable iff (!hresetn)
		(!auto_restart_enable && ase_r && !wr_sdc) |=> ase_r)
		else $error("status cleared without restart enable");

	a_resume_period: assert property (@(posedge hclk) disable iff (!hresetn)
		$fell(hold_r) |-> $past(period_start) && !$past(ase_r))
		else $error("outputs resumed off a period start");

	a_park_low: assert property (@(posedge hclk) disable iff (!hresetn)
		(forced && en[0] && pair_ac_shutdown_level == bridge_pwm_pkg::LVL_DRIVE0)
		|=> pins_r.oe[0] && !pins_r.lvl[0])
		else $error("pair A/C not parked low");

	a_steer_off: assert property (@(posedge hclk) disable iff (!hresetn)
		(steering && !en[1]) |=> !pins_r.oe[1])
		else $error("unsteered output driven");

	a_db_zero: assert property (@(posedge hclk) disable iff (!hresetn)
		(half && !forced && deadband_count == 7'h00 && pwm_in)
		|=> pins_r.lvl[0] == ~pol_ac && pins_r.lvl[1] == pol_bd)
		else $error("zero dead-band delayed the output");

	a_steer_sync: assert property (@(posedge hclk) disable iff (!hresetn)
		(steering_sync_select && !period_start) |=> $stable(steer_r))
		else $error("synchronised steering moved mid period");
endmodule

// ---- design/bridge_pwm_pkg.sv ----
package bridge_pwm_pkg;
	// ==========================================================
	// register byte offsets
	localparam logic [7:0] CHANNEL_CONTROL_OFS = 8'h00;
	localparam logic [7:0] SHUTDOWN_CONTROL_OFS = 8'h04;
	localparam logic [7:0] DEADBAND_RESTART_OFS = 8'h08;
	localparam logic [7:0] STEERING_CONTROL_OFS = 8'h0C;
	localparam logic [7:0] STATUS_OFS = 8'h10;
	// ==========================================================
	// field positions
	localparam int CFG_POS = 6;
	localparam int MODE_UP_POS = 2;
	localparam int POL_POS = 0;
	localparam int ASE_POS = 7;
	localparam int SRC_POS = 4;
	localparam int LVL_AC_POS = 2;
	localparam int LVL_BD_POS = 0;
	localparam int RSEN_POS = 7;
	localparam int DBC_POS = 0;
	localparam int SYNC_POS = 4;
	localparam int STEER_POS = 0;
	// ==========================================================
	// reset values
	localparam logic [7:0] CHANNEL_CONTROL_RST = 8'h00;
	localparam logic [7:0] SHUTDOWN_CONTROL_RST = 8'h00;
	localparam logic [7:0] DEADBAND_RESTART_RST = 8'h00;
	localparam logic [4:0] STEERING_CONTROL_RST = 5'h01;
	// ==========================================================
	// encodings and timing
	localparam logic [1:0] CFG_SINGLE = 2'h0;
	localparam logic [1:0] CFG_HALF = 2'h2;
	localparam logic [1:0] MODE_PWM = 2'h3;
	localparam logic [1:0] LVL_DRIVE0 = 2'h0;
	localparam logic [1:0] LVL_DRIVE1 = 2'h1;
	localparam int DIR_LEAD_COUNTS = 4;
	localparam int CLK_MHZ = 100;

	// one bit per output, index 0 is A through 3 is D
	typedef struct packed {
		logic [3:0] lvl;
		logic [3:0] oe;
	} pins_t;

	// captured address phase
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
	} bus_req_t;
endpackage

// ---- sim/bridge_pwm_load_model.sv ----
`timescale 1ns/1ps
// ==========================================================
// far side: gate drivers of the power bridge, pull-down on each pin
module bridge_pwm_load_model (
	input wire logic [3:0] lvl,
	input wire logic [3:0] oe,
	output logic [3:0] gate
);
	// pin drivers enabled
	// a released pin falls to its pull-down, so a switch is never left half on
	assign gate = lvl & oe;
endmodule

// ---- sim/bridge_pwm_output_control_tb_top.sv ----
`timescale 1ns/1ps
module bridge_pwm_output_control_tb_top;
	localparam logic [7:0] CH = bridge_pwm_pkg::CHANNEL_CONTROL_OFS;
	localparam logic [7:0] SD = bridge_pwm_pkg::SHUTDOWN_CONTROL_OFS;
	localparam logic [7:0] DB = bridge_pwm_pkg::DEADBAND_RESTART_OFS;
	localparam logic [7:0] ST = bridge_pwm_pkg::STEERING_CONTROL_OFS;
	logic hclk, hresetn, hsel, hwrite, pwm_in, period_start, int_pin_n, comparator_output;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic hreadyout, hresp;
	logic [7:0] tmr_count, tmr_period;
	logic [3:0] gate;
	wire bridge_pwm_pkg::pins_t pins;
	int n_fail, check_count, cycles;

	// ==========================================================
	// design and far side
	bridge_pwm_output_control #(.TMR_W(8)) bridge_pwm_output_control_i (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .pwm_in(pwm_in),
		.period_start(period_start), .tmr_count(tmr_count), .tmr_period(tmr_period),
		.int_pin_n(int_pin_n), .comparator_output(comparator_output),
		.pwm_out_a(pins.lvl[0]), .pwm_out_a_oe(pins.oe[0]),
		.pwm_out_b(pins.lvl[1]), .pwm_out_b_oe(pins.oe[1]),
		.pwm_out_c(pins.lvl[2]), .pwm_out_c_oe(pins.oe[2]),
		.pwm_out_d(pins.lvl[3]), .pwm_out_d_oe(pins.oe[3])
	);
	bridge_pwm_load_model bridge_pwm_load_model_i (.lvl(pins.lvl), .oe(pins.oe), .gate(gate));

	// ==========================================================
	// clock, timer stand-in and hang guard
	initial begin
		hclk = 1'b0;
		forever #5 hclk = ~hclk;
	end
	// timer wraps at tmr_period; period_start pulses as it returns to zero
	always @(posedge hclk) begin
		tmr_count <= (tmr_count == tmr_period) ? 8'h00 : tmr_count + 8'h01;
		period_start <= (tmr_count == tmr_period);
		cycles = cycles + 1;
		if (cycles == 5000) begin
			n_fail++;
			stop_test();
		end
	end

	// ==========================================================
	// shared tasks
	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string m);
		check_count++;
		if (seen !== exp) begin
			n_fail++;
			$display("unexpected at %0t: %s seen %h expected %h", $time, m, seen, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge hclk);
		#1;
	endtask
	task automatic wait_start();
		do @(posedge hclk); while (period_start !== 1'b1);
	endtask
	// address phase held until hready, then data phase held until hready
	task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= {24'h000000, a};
		htrans <= 2'h2;
		hwrite <= w;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= {24'h000000, d};
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		bus(1'b1, a, d);
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
		bus(1'b0, a, 8'h00);
		check(rd, {24'h000000, exp}, "register read");
	endtask
	task automatic pchk(input logic [3:0] lvl, input logic [3:0] oe);
		check({24'h000000, pins.oe, pins.lvl}, {24'h000000, oe, lvl}, "pin state");
	endtask

	// ==========================================================
	// scenarios
	task automatic t_reset();
		pchk(4'h0, 4'h0);
		@(posedge hclk);
		hresetn <= 1'b1;
		rdchk(CH, 8'h00);
		rdchk(SD, 8'h00);
		rdchk(DB, 8'h00);
		rdchk(ST, 8'h01);
		wr(8'h20, 8'hFF);
		rdchk(8'h20, 8'h00);
		check({31'h0, hresp}, 32'h0, "response");
		$display("test reset done");
	endtask
	task automatic t_steer();
		wr(CH, 8'h0C);
		wr(ST, 8'h0F);
		pwm_in <= 1'b1;
		wait_start();
		cyc(3);
		pchk(4'hF, 4'hF);
		pwm_in <= 1'b0;
		cyc(2);
		pchk(4'h0, 4'hF);
		wr(CH, 8'h0F);
		cyc(2);
		pchk(4'hF, 4'hF);
		wr(ST, 8'h05);
		cyc(2);
		pchk(4'h5, 4'h5);
		wait_start();
		wr(ST, 8'h13);
		cyc(2);
		pchk(4'h5, 4'h5);
		wait_start();
		cyc(3);
		pchk(4'h3, 4'h3);
		wr(SD, 8'h85);
		cyc(1);
		pchk(4'h3, 4'h3);
		wr(SD, 8'h05);
		$display("test steering done");
	endtask
	task automatic t_half();
		logic s;
		s = 1'b0;
		wr(DB, 8'h03);
		wr(CH, 8'h8C);
		wait_start();
		cyc(3);
		pchk(4'h2, 4'h3);
		@(posedge hclk);
		pwm_in <= 1'b1;
		cyc(3);
		pchk(4'h0, 4'h3);
		cyc(1);
		pchk(4'h1, 4'h3);
		wr(DB, 8'h00);
		@(posedge hclk);
		pwm_in <= 1'b0;
		cyc(1);
		pchk(4'h2, 4'h3);
		wr(DB, 8'h0A);
		@(posedge hclk);
		pwm_in <= 1'b1;
		for (int i = 0; i < 12; i++) begin
			@(posedge hclk);
			if (i == 4) pwm_in <= 1'b0;
			#1;
			s = s | pins.lvl[0];
		end
		check({31'h0, s}, 32'h0, "short pulse");
		$display("test half bridge done");
	endtask
	task automatic t_full();
		wr(CH, 8'h4C);
		pwm_in <= 1'b1;
		wait_start();
		cyc(3);
		pchk(4'h9, 4'hF);
		pwm_in <= 1'b0;
		cyc(1);
		pchk(4'h1, 4'hF);
		pwm_in <= 1'b1;
		cyc(1);
		pchk(4'h9, 4'hF);
		// duty lowered for a period before reversing
		pwm_in <= 1'b0;
		wait_start();
		wr(CH, 8'hCC);
		cyc(1);
		pchk(4'h1, 4'hF);
		do @(posedge hclk); while (tmr_count !== tmr_period - 8'(bridge_pwm_pkg::DIR_LEAD_COUNTS));
		pwm_in <= 1'b1;
		cyc(2);
		pchk(4'h4, 4'hF);
		wait_start();
		cyc(2);
		pchk(4'h6, 4'hF);
		$display("test full bridge done");
	endtask
	task automatic t_shut();
		wr(SD, 8'h86);
		cyc(1);
		pchk(4'h5, 4'h5);
		check({28'h0, gate}, 32'h5, "released pins");
		rdchk(SD, 8'h86);
		wr(SD, 8'h06);
		cyc(0);
		pchk(4'h5, 4'h5);
		rdchk(SD, 8'h06);
		wait_start();
		cyc(2);
		pchk(4'h6, 4'hF);
		wr(SD, 8'h16);
		@(posedge hclk);
		comparator_output <= 1'b1;
		cyc(4);
		pchk(4'h5, 4'h5);
		wr(SD, 8'h16);
		rdchk(SD, 8'h96);
		comparator_output <= 1'b0;
		cyc(3);
		rdchk(SD, 8'h96);
		wr(SD, 8'h16);
		wait_start();
		cyc(2);
		pchk(4'h6, 4'hF);
		wr(DB, 8'h80);
		wr(SD, 8'h20);
		@(posedge hclk);
		int_pin_n <= 1'b0;
		cyc(4);
		pchk(4'h0, 4'hF);
		rdchk(SD, 8'hA0);
		int_pin_n <= 1'b1;
		cyc(4);
		rdchk(SD, 8'h20);
		wait_start();
		cyc(2);
		pchk(4'h6, 4'hF);
		$display("test shutdown done");
	endtask

	// ==========================================================
	// verdict
	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	// reset for three cycles, then the scenarios in turn
	initial begin
		{hresetn, hsel, hwrite, pwm_in, period_start, comparator_output} = 6'h00;
		{haddr, hwdata, htrans} = 66'h0;
		hsize = 3'h2;
		int_pin_n = 1'b1;
		tmr_count = 8'h00;
		tmr_period = 8'd19;
		{n_fail, check_count, cycles} = 96'h0;
		repeat (3) @(posedge hclk);
		#1;
		t_reset();
		t_steer();
		t_half();
		t_full();
		t_shut();
		stop_test();
	end
endmodule
